// [logic/cbc_pkg.sv]
// Purpose: Shared constants and types for the calibration button controller.
// Assumes: 10 MHz system clock.
// Notes: Register offsets live here too; the bus is a plain strobe port.
package cbc_pkg;
    localparam int unsigned CLK_HZ = 10000000;
    // Press timing
    localparam int unsigned LONG_PRESS_MS = 2000;
    localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_MS * (CLK_HZ / 1000);
    localparam int unsigned DEBOUNCE_US = 10000;
    localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1000000);
    // Indicator blink half period
    localparam int unsigned BLINK_HALF_MS = 250;
    localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
    // Blink counts per event
    localparam logic [2:0] BLINKS_GAIN = 3'h2;
    localparam logic [2:0] BLINKS_OFFSET = 3'h4;
    localparam logic [2:0] BLINKS_SAVE = 3'h1;
    localparam logic [2:0] BLINKS_AZERO = 3'h6;
    // Parameter widths and steps
    localparam int unsigned PARAM_W = 8;
    localparam logic [7:0] COARSE_STEP = 8'h10;
    localparam logic [7:0] FINE_STEP = 8'h01;
    localparam logic [7:0] GAIN_RST = 8'h80;
    localparam logic [7:0] OFFSET_RST = 8'h80;
    localparam logic [7:0] ZERO_MID = 8'h80;
    // Register offsets
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MASK = 4'h1;
    localparam logic [3:0] ADDR_PARAMS = 4'h2;
    localparam logic [3:0] ADDR_SWITCH = 4'h3;
    localparam logic [3:0] ADDR_MODE = 4'h4;
    // Status bit positions
    localparam int unsigned ST_SAVED = 0;
    localparam int unsigned ST_AZERO = 1;
    localparam int unsigned ST_FAULT = 2;
    localparam int unsigned ST_ABORT = 3;
    localparam int unsigned ST_W = 4;
    // Shaft family codes
    localparam logic [1:0] FAM_STD = 2'h0;
    localparam logic [1:0] FAM_ALT1 = 2'h3;
    localparam logic [1:0] FAM_ALT2 = 2'h1;

    typedef enum logic [2:0] {
        CBC_MEASURE,
        CBC_GAIN,
        CBC_OFFSET
    } cbc_mode_t;
endpackage : cbc_pkg

// [logic/cbc_press_if.sv]
// Purpose: Carries classified press events from a button timer.
// Assumes: Single clock domain.
// Notes: Pulses are one cycle long.
`timescale 1ns/1ps
interface cbc_press_if;
    logic short_p;
    logic long_p;
    modport timer (output short_p, output long_p);
    modport ctrl (input short_p, input long_p);
endinterface : cbc_press_if

// [logic/cbc_button.sv]
// Purpose: Debounce one button and class each press as short or long.
// Assumes: Active-high button level, synchronous to sys_clk_i.
// Notes: Long fires once at the threshold; release after it gives nothing.
`timescale 1ns/1ps
module cbc_button #(
    parameter int unsigned DEB_CYC = cbc_pkg::DEBOUNCE_CYC,
    parameter int unsigned LONG_CYC = cbc_pkg::LONG_PRESS_CYC
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic button_i,
    cbc_press_if.timer press
);
    import cbc_pkg::*;
    // Counter widths follow the counts, so a long debounce cannot wrap early
    localparam int unsigned DEB_W = $clog2(DEB_CYC + 1);
    localparam int unsigned HOLD_W = $clog2(LONG_CYC + 1);
    logic [DEB_W-1:0] deb_r, deb_nxt;
    logic stable_r, stable_nxt;
    logic [HOLD_W-1:0] hold_r, hold_nxt;
    logic long_done_r, long_done_nxt;
    logic short_nxt, long_nxt;

    // Debounce, then time the held level
    always_comb begin
        deb_nxt = deb_r;
        stable_nxt = stable_r;
        hold_nxt = hold_r;
        long_done_nxt = long_done_r;
        short_nxt = 1'b0;
        long_nxt = 1'b0;
        if (button_i == stable_r) begin
            deb_nxt = '0;
        end else if (deb_r == DEB_W'(DEB_CYC - 1)) begin
            deb_nxt = '0;
            stable_nxt = button_i;
            if (!button_i && !long_done_r) begin
                short_nxt = 1'b1;
            end
            hold_nxt = '0;
            long_done_nxt = 1'b0;
        end else begin
            deb_nxt = deb_r + DEB_W'(1);
        end
        if (stable_r && stable_nxt && !long_done_r) begin
            if (hold_r == HOLD_W'(LONG_CYC - 1)) begin
                long_nxt = 1'b1;
                long_done_nxt = 1'b1;
            end else begin
                hold_nxt = hold_r + HOLD_W'(1);
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            deb_r <= '0;
            stable_r <= 1'b0;
            hold_r <= '0;
            long_done_r <= 1'b0;
            press.short_p <= 1'b0;
            press.long_p <= 1'b0;
        end else begin
            deb_r <= deb_nxt;
            stable_r <= stable_nxt;
            hold_r <= hold_nxt;
            long_done_r <= long_done_nxt;
            press.short_p <= short_nxt;
            press.long_p <= long_nxt;
        end
    end
endmodule : cbc_button

// [logic/cbc_top.sv]
// Purpose: Calibration mode control, indicator lamps and register port.
// Assumes: 10 MHz clock; nonvolatile store is an external word port.
// Notes: Power loss is modelled by reset; working values reload from the store.
`timescale 1ns/1ps

module cbc_top #(
    parameter int unsigned LONG_CYC = cbc_pkg::LONG_PRESS_CYC,
    parameter int unsigned DEB_CYC = cbc_pkg::DEBOUNCE_CYC,
    parameter int unsigned BLINK_CYC = cbc_pkg::BLINK_HALF_CYC
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic auto_zero_button_i,
    input wire logic auto_zero_terminal_i,
    input wire logic program_button_i,
    input wire logic defect_i,
    input wire logic [3:0] speed_range_switches_i,
    input wire logic family_select_low_i,
    input wire logic family_select_high_i,
    input wire logic [15:0] nv_data_i,
    output logic nv_write_o,
    output logic [15:0] nv_data_o,
    output logic [cbc_pkg::PARAM_W-1:0] gain_o,
    output logic [cbc_pkg::PARAM_W-1:0] offset_o,
    output logic [3:0] speed_range_o,
    output logic [1:0] family_o,
    output logic mode_indicator_lamp_o,
    output logic fault_indicator_lamp_o,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [31:0] reg_rdata_o,
    output logic irq_o
);
    import cbc_pkg::*;

    // Each button has its own debounce and hold timer. A long press is
    // reported when the hold threshold is reached, not at release, so the
    // lamp answers while the finger is still on the button.
    cbc_press_if zero_press ();
    cbc_press_if prog_press ();
    logic zero_level;

    // Terminal and button share one timer, so both behave alike; a control
    // system holding the terminal while someone presses the button simply
    // looks like one longer press.
    assign zero_level = auto_zero_button_i | auto_zero_terminal_i;

    cbc_button #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_zero (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .button_i(zero_level),
        .press(zero_press)
    );

    cbc_button #(.DEB_CYC(DEB_CYC), .LONG_CYC(LONG_CYC)) u_prog (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .button_i(program_button_i),
        .press(prog_press)
    );

    // Working values live only in flip-flops. A power loss is a reset, so
    // an unfinished calibration is dropped and the stored word comes back;
    // the store is written only by a save or an auto-zero, never while the
    // operator is still stepping, which keeps wear on it low.
    cbc_mode_t mode_r, mode_nxt;
    logic [7:0] gain_r, gain_nxt;
    logic [7:0] offset_r, offset_nxt;
    logic load_r, load_nxt;
    logic nv_wr_r, nv_wr_nxt;
    logic [15:0] nv_dat_r, nv_dat_nxt;
    logic [2:0] blink_req;
    logic saved_ev, azero_ev, abort_ev;

    // Mode machine and parameter stepping
    // A program long press beats any zero event of the same cycle, and all
    // steps wrap at the word edge so every setting can be reached. Short
    // presses in measuring mode and zero long presses during calibration
    // are ignored on purpose: neither has a meaning there.
    always_comb begin
        mode_nxt = mode_r;
        gain_nxt = gain_r;
        offset_nxt = offset_r;
        load_nxt = 1'b0;
        nv_wr_nxt = 1'b0;
        nv_dat_nxt = nv_dat_r;
        blink_req = 3'h0;
        saved_ev = 1'b0;
        azero_ev = 1'b0;
        abort_ev = 1'b0;
        if (load_r) begin
            // First cycle after power-up: restore stored values. Presses are
            // ignored for this one cycle; no debounce can finish that soon.
            gain_nxt = nv_data_i[15:8];
            offset_nxt = nv_data_i[7:0];
        end else begin
            unique case (mode_r)
                CBC_MEASURE: begin
                    if (prog_press.long_p) begin
                        mode_nxt = CBC_GAIN;
                        blink_req = BLINKS_GAIN;
                    end else if (zero_press.long_p) begin
                        // Live torque is analog; midpoint code stands for 5,0 V
                        offset_nxt = ZERO_MID;
                        nv_wr_nxt = 1'b1;
                        nv_dat_nxt = {gain_r, ZERO_MID};
                        blink_req = BLINKS_AZERO;
                        azero_ev = 1'b1;
                    end
                end
                CBC_GAIN: begin
                    if (prog_press.long_p) begin
                        mode_nxt = CBC_OFFSET;
                        blink_req = BLINKS_OFFSET;
                    end else if (zero_press.short_p) begin
                        gain_nxt = gain_r + COARSE_STEP;
                    end else if (prog_press.short_p) begin
                        gain_nxt = gain_r + FINE_STEP;
                    end
                end
                CBC_OFFSET: begin
                    if (prog_press.long_p) begin
                        mode_nxt = CBC_MEASURE;
                        nv_wr_nxt = 1'b1;
                        nv_dat_nxt = {gain_r, offset_r};
                        blink_req = BLINKS_SAVE;
                        saved_ev = 1'b1;
                    end else if (zero_press.short_p) begin
                        offset_nxt = offset_r + COARSE_STEP;
                    end else if (prog_press.short_p) begin
                        offset_nxt = offset_r + FINE_STEP;
                    end
                end
                default: begin
                    mode_nxt = CBC_MEASURE;
                    abort_ev = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mode_r <= CBC_MEASURE;
            gain_r <= GAIN_RST;
            offset_r <= OFFSET_RST;
            load_r <= 1'b1;
            nv_wr_r <= 1'b0;
            nv_dat_r <= '0;
        end else begin
            mode_r <= mode_nxt;
            gain_r <= gain_nxt;
            offset_r <= offset_nxt;
            load_r <= load_nxt;
            nv_wr_r <= nv_wr_nxt;
            nv_dat_r <= nv_dat_nxt;
        end
    end

    // Store port: the word and its strobe leave flip-flops together,
    // so the store never catches a half-updated word.
    assign nv_write_o = nv_wr_r;
    assign nv_data_o = nv_dat_r;
    assign gain_o = gain_r;
    assign offset_o = offset_r;

    // Blink sequencer: counts half periods of the program lamp.
    // A request of n blinks loads 2n half periods; the lamp toggles at the
    // end of each and is forced off at the last, so a pattern ends dark.
    // A newer request cuts a running pattern short: the latest event is
    // the one the operator needs to see.
    logic [23:0] bdiv_r, bdiv_nxt;
    logic [3:0] bhalf_r, bhalf_nxt;
    logic lamp_r, lamp_nxt;
    always_comb begin
        bdiv_nxt = bdiv_r;
        bhalf_nxt = bhalf_r;
        lamp_nxt = lamp_r;
        if (blink_req != 3'h0) begin
            // New request restarts the pattern
            bhalf_nxt = {blink_req, 1'b0};
            bdiv_nxt = '0;
            lamp_nxt = 1'b1;
        end else if (bhalf_r != 4'h0) begin
            if (bdiv_r == 24'(BLINK_CYC - 1)) begin
                bdiv_nxt = '0;
                bhalf_nxt = bhalf_r - 4'h1;
                lamp_nxt = (bhalf_r != 4'h1) && !lamp_r;
            end else begin
                bdiv_nxt = bdiv_r + 24'h000001;
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            bdiv_r <= '0;
            bhalf_r <= '0;
            lamp_r <= 1'b0;
        end else begin
            bdiv_r <= bdiv_nxt;
            bhalf_r <= bhalf_nxt;
            lamp_r <= lamp_nxt;
        end
    end

    // Static switches and lamps, registered to keep outputs glitch free.
    // One stage is enough: the switches are set by hand and never race the
    // clock. The fault lamp follows the defect flag with the same lag and
    // goes dark again as soon as the defect is gone.
    logic fault_r;
    logic [3:0] range_r;
    logic [1:0] fam_r;
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            fault_r <= 1'b0;
            range_r <= '0;
            fam_r <= FAM_STD;
        end else begin
            fault_r <= defect_i;
            range_r <= speed_range_switches_i;
            fam_r <= {family_select_high_i, family_select_low_i};
        end
    end
    assign mode_indicator_lamp_o = lamp_r;
    assign fault_indicator_lamp_o = fault_r;
    assign speed_range_o = range_r;
    assign family_o = fam_r;

    // Register map, one word each, unused bits read as zero:
    //   0 status, write one to clear: saved, auto-zero done, fault, abort
    //   1 interrupt mask, same layout as status
    //   2 working gain above working offset, read only
    //   3 switch copies, family above speed range, read only
    //   4 calibration mode: measure, gain, offset
    // Writes to read-only or unmapped words are dropped without an error.
    // The fault bit marks the rising edge of a defect only, so a lasting
    // defect raises it once rather than refilling it after every clear.

    // Sticky status, write one to clear; a set in the same cycle wins
    logic [ST_W-1:0] status_r, status_nxt, mask_r, mask_nxt, ev;
    logic [31:0] rdata_r, rdata_nxt;
    always_comb begin
        ev = '0;
        ev[ST_SAVED] = saved_ev;
        ev[ST_AZERO] = azero_ev;
        ev[ST_FAULT] = defect_i & ~fault_r;
        ev[ST_ABORT] = abort_ev;
        status_nxt = status_r;
        mask_nxt = mask_r;
        if (reg_write_i && reg_addr_i == ADDR_STATUS) begin
            status_nxt = status_r & ~reg_wdata_i[ST_W-1:0];
        end
        if (reg_write_i && reg_addr_i == ADDR_MASK) begin
            mask_nxt = reg_wdata_i[ST_W-1:0];
        end
        status_nxt = status_nxt | ev;
        rdata_nxt = '0;
        if (reg_read_i) begin
            unique case (reg_addr_i)
                ADDR_STATUS: rdata_nxt = {28'h0, status_r};
                ADDR_MASK: rdata_nxt = {28'h0, mask_r};
                ADDR_PARAMS: rdata_nxt = {16'h0, gain_r, offset_r};
                ADDR_SWITCH: rdata_nxt = {26'h0, fam_r, range_r};
                ADDR_MODE: rdata_nxt = {29'h0, mode_r};
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            status_r <= '0;
            mask_r <= '0;
            rdata_r <= '0;
        end else begin
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Read data stand for one cycle after the strobe and are zero otherwise,
    // so a bus that ORs several slaves together needs no extra select.
    assign reg_rdata_o = rdata_r;
    // The interrupt is a level: it stays up until software clears the
    // status bit or masks it off.
    assign irq_o = |(status_r & mask_r);
endmodule : cbc_top

// [verif/cbc_properties.sv]
// Purpose: Port assertions for the calibration button controller.
// Assumes: One clock, async active-high reset.
// Notes: Hold and blink lengths follow the top's parameters.
`timescale 1ns/1ps
module cbc_properties #(
    parameter int unsigned LONG_CYC = 20,
    parameter int unsigned DEB_CYC = 3,
    parameter int unsigned BLINK_CYC = 4
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic program_button_i,
    input wire logic defect_i,
    input wire logic [3:0] speed_range_switches_i,
    input wire logic family_select_low_i,
    input wire logic family_select_high_i,
    input wire logic [15:0] nv_data_i,
    input wire logic nv_write_o,
    input wire logic [15:0] nv_data_o,
    input wire logic [cbc_pkg::PARAM_W-1:0] gain_o,
    input wire logic [cbc_pkg::PARAM_W-1:0] offset_o,
    input wire logic [3:0] speed_range_o,
    input wire logic [1:0] family_o,
    input wire logic mode_indicator_lamp_o,
    input wire logic fault_indicator_lamp_o,
    input wire logic reg_read_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic irq_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    logic [7:0] held_r, held_nxt, high_r, high_nxt;
    // Run lengths of a program hold and of a lamp pulse; saturate so they never wrap
    always_comb begin
        held_nxt = !program_button_i ? 8'h0 : (held_r == 8'hff) ? held_r : held_r + 8'h1;
        high_nxt = !mode_indicator_lamp_o ? 8'h0 : (high_r == 8'hff) ? high_r : high_r + 8'h1;
    end
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            held_r <= 8'h0;
            high_r <= 8'h0;
        end else begin
            held_r <= held_nxt;
            high_r <= high_nxt;
        end
    end
    // Copies of static inputs lag one cycle
    fault_follow_a: assert property (!$past(reset_i) |->
        fault_indicator_lamp_o == $past(defect_i))
        else $error("fault lamp does not follow defect");
    range_follow_a: assert property (!$past(reset_i) |->
        speed_range_o == $past(speed_range_switches_i))
        else $error("speed range does not follow switches");
    family_follow_a: assert property (!$past(reset_i) |->
        family_o == $past({family_select_high_i, family_select_low_i}))
        else $error("family code does not follow switches");
    rdata_idle_a: assert property (!$past(reg_read_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside its cycle");
    prog_long_a: assert property (int'(held_r) == DEB_CYC + LONG_CYC + 2 |->
        ##[0:8] mode_indicator_lamp_o)
        else $error("long program hold gave no blink");
    blink_len_a: assert property ($fell(mode_indicator_lamp_o) |->
        int'(high_r) == BLINK_CYC)
        else $error("blink on time wrong");
    nv_pulse_a: assert property (nv_write_o |=> !nv_write_o)
        else $error("store write longer than one cycle");
    nv_data_a: assert property (nv_write_o |-> ##[0:1] nv_data_o == {gain_o, offset_o})
        else $error("stored word differs from working values");
    reload_a: assert property ($fell(reset_i) |->
        ##[1:3] {gain_o, offset_o} == nv_data_i)
        else $error("stored values not reloaded");
    cover property (nv_write_o);
    cover property ($rose(mode_indicator_lamp_o));
    cover property (irq_o);
endmodule : cbc_properties

bind cbc_top cbc_properties #(
    .LONG_CYC(LONG_CYC),
    .DEB_CYC(DEB_CYC),
    .BLINK_CYC(BLINK_CYC)
) u_props (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .program_button_i(program_button_i),
    .defect_i(defect_i),
    .speed_range_switches_i(speed_range_switches_i),
    .family_select_low_i(family_select_low_i),
    .family_select_high_i(family_select_high_i),
    .nv_data_i(nv_data_i),
    .nv_write_o(nv_write_o),
    .nv_data_o(nv_data_o),
    .gain_o(gain_o),
    .offset_o(offset_o),
    .speed_range_o(speed_range_o),
    .family_o(family_o),
    .mode_indicator_lamp_o(mode_indicator_lamp_o),
    .fault_indicator_lamp_o(fault_indicator_lamp_o),
    .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o),
    .irq_o(irq_o)
);

// [verif/cbc_operator_model.sv]
// Purpose: Operator buttons and nonvolatile store beside the controller.
// Assumes: The bench asks for one press at a time.
// Notes: The store has no reset, so saved words survive power loss.
`timescale 1ns/1ps
module cbc_operator_model #(
    parameter logic [15:0] INIT_WORD = 16'h3c5a
) (
    input wire logic sys_clk_i,
    input wire logic go_i,
    input wire logic [1:0] which_i,
    input wire logic [15:0] hold_i,
    input wire logic nv_write_i,
    input wire logic [15:0] nv_data_i,
    output logic auto_zero_button_o,
    output logic auto_zero_terminal_o,
    output logic program_button_o,
    output logic done_o,
    output logic [15:0] nv_word_o
);
    localparam logic [15:0] GAP = 16'ha;
    logic [15:0] cnt_r = 16'h0;
    logic [15:0] word_r = INIT_WORD;
    // Hold, then a release gap of 10 cycles, longer than the bench's 3-cycle debounce
    always_ff @(posedge sys_clk_i) begin
        if (cnt_r != 16'h0) begin
            cnt_r <= cnt_r - 16'h1;
        end else if (go_i) begin
            cnt_r <= hold_i + GAP;
        end
        if (nv_write_i) begin
            word_r <= nv_data_i;
        end
    end
    // A released button reads as not pressed
    assign auto_zero_button_o = (cnt_r > GAP) && (which_i == 2'h0);
    assign auto_zero_terminal_o = (cnt_r > GAP) && (which_i == 2'h1);
    assign program_button_o = (cnt_r > GAP) && (which_i == 2'h2);
    assign done_o = (cnt_r == 16'h0);
    assign nv_word_o = word_r;
endmodule : cbc_operator_model

// [verif/testbench.sv]
// Purpose: Directed bench for the calibration button controller.
// Assumes: Shortened hold, debounce and blink counts.
// Notes: Blinks are counted by a monitor, so their phase does not matter.
`timescale 1ns/1ps
module testbench;
    import cbc_pkg::*;
    localparam logic [15:0] LONGH = 16'd29;
    localparam logic [15:0] SHORTH = 16'd7;
    logic clk = 1'b0, rst = 1'b1, defect = 1'b0, wr_s = 1'b0, rd_s = 1'b0, go = 1'b0;
    logic az_b, az_t, pb, done, nv_wr, lamp, flamp, irq, lamp_q = 1'b0;
    logic [1:0] which = 2'h0, fam = 2'h0, fam_o;
    logic [3:0] sw = 4'h0, rng_o, addr = 4'h0;
    logic [15:0] hold = 16'h0, nv_do, nv_word;
    logic [7:0] gain, offset;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] fams [3] = '{FAM_STD, FAM_ALT1, FAM_ALT2};
    logic [3:0] rngs [3] = '{4'h0, 4'h7, 4'hf};
    int num_errors = 0, n_tests = 0, nbl = 0;
    initial begin
        forever #50 clk = ~clk;
    end
    cbc_top #(.LONG_CYC(20), .DEB_CYC(3), .BLINK_CYC(4)) u_dut (
        .sys_clk_i(clk), .reset_i(rst), .auto_zero_button_i(az_b),
        .auto_zero_terminal_i(az_t), .program_button_i(pb), .defect_i(defect),
        .speed_range_switches_i(sw), .family_select_low_i(fam[0]),
        .family_select_high_i(fam[1]), .nv_data_i(nv_word), .nv_write_o(nv_wr),
        .nv_data_o(nv_do), .gain_o(gain), .offset_o(offset), .speed_range_o(rng_o),
        .family_o(fam_o), .mode_indicator_lamp_o(lamp), .fault_indicator_lamp_o(flamp),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr_s), .reg_read_i(rd_s),
        .reg_rdata_o(rdata), .irq_o(irq));
    cbc_operator_model u_oper (
        .sys_clk_i(clk), .go_i(go), .which_i(which), .hold_i(hold), .nv_write_i(nv_wr),
        .nv_data_i(nv_do), .auto_zero_button_o(az_b), .auto_zero_terminal_o(az_t),
        .program_button_o(pb), .done_o(done), .nv_word_o(nv_word));
    // Count lamp turn-ons
    always @(posedge clk) begin
        if (lamp === 1'b1 && lamp_q === 1'b0) nbl++;
        lamp_q <= lamp;
    end
    task automatic tally_and_finish();
        if (num_errors == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        #1;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk(rdata, e);
    endtask : rdchk
    task automatic press(input logic [1:0] w, input logic [15:0] h);
        which <= w;
        hold <= h;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        #1;
        for (int i = 0; i < 200 && done !== 1'b1; i++) wt(1);
        if (done !== 1'b1) begin
            num_errors++;
            tally_and_finish();
        end
    endtask : press
    task automatic lng(input logic [1:0] w);
        nbl = 0;
        press(w, LONGH);
        wt(60);
    endtask : lng
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        wt(4);
        chk({gain, offset}, 32'h3c5a);
        for (int i = 0; i < 3; i++) begin
            sw <= rngs[i];
            fam <= fams[i];
            wt(2);
            chk({fam_o, rng_o}, {fams[i], rngs[i]});
            rdchk(ADDR_SWITCH, {26'h0, fams[i], rngs[i]});
        end
        // Fault raises status bit 2 and, once unmasked, the interrupt
        wr(ADDR_MASK, 32'h4);
        defect <= 1'b1;
        wt(3);
        chk({flamp, irq}, 32'h3);
        defect <= 1'b0;
        wt(2);
        chk(flamp, 32'h0);
        rdchk(ADDR_STATUS, 32'h4);
        wr(ADDR_STATUS, 32'h4);
        wr(ADDR_MASK, 32'h3);
        defect <= 1'b1;
        wt(3);
        chk(irq, 32'h0);
        rdchk(ADDR_STATUS, 32'h4);
        defect <= 1'b0;
        wr(ADDR_STATUS, 32'h4);
        rdchk(ADDR_STATUS, 32'h0);
        // Refused accesses and presses
        rdchk(4'hf, 32'h0);
        wr(ADDR_PARAMS, 32'hffff);
        press(2'h2, SHORTH);
        rdchk(ADDR_PARAMS, 32'h3c5a);
        rdchk(ADDR_MODE, 32'h0);
        lng(2'h2);
        rdchk(ADDR_MODE, 32'h1);
        chk(nbl, 32'h2);
        press(2'h0, 16'h1);
        chk(gain, 32'h3c);
        press(2'h0, SHORTH);
        chk(gain, 32'h4c);
        press(2'h2, SHORTH);
        chk(gain, 32'h4d);
        for (int i = 0; i < 15; i++) press(2'h0, SHORTH);
        chk(gain, 32'h3d);
        lng(2'h2);
        rdchk(ADDR_MODE, 32'h2);
        chk(nbl, 32'h4);
        press(2'h0, SHORTH);
        press(2'h2, SHORTH);
        chk({gain, offset}, 32'h3d6b);
        lng(2'h2);
        rdchk(ADDR_MODE, 32'h0);
        chk(nbl, 32'h1);
        chk(nv_word, 32'h3d6b);
        rdchk(ADDR_STATUS, 32'h1);
        chk(irq, 32'h1);
        wr(ADDR_STATUS, 32'h1);
        // Power loss in mid-calibration
        lng(2'h2);
        press(2'h0, SHORTH);
        chk(gain, 32'h4d);
        lng(2'h0);
        chk(nbl, 32'h0);
        chk({gain, offset}, 32'h4d6b);
        rst <= 1'b1;
        wt(2);
        rst <= 1'b0;
        wt(4);
        chk({gain, offset}, 32'h3d6b);
        rdchk(ADDR_MODE, 32'h0);
        lng(2'h1);
        chk({gain, offset}, 32'h3d80);
        chk(nbl, 32'h6);
        chk(nv_word, 32'h3d80);
        rdchk(ADDR_STATUS, 32'h2);
        tally_and_finish();
    end
endmodule : testbench
